// ===== wdrg_defs.vh
// Constants for the watchdog and reset guard block
`ifndef WDRG_DEFS_VH
`define WDRG_DEFS_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define WDRG_OFS_WDT_CTRL 8'h00
`define WDRG_OFS_RST_FLAGS 8'h04
`define WDRG_OFS_GUARD 8'h08
`define WDRG_OFS_STATUS 8'h0C
`define WDRG_OFS_CPU_CMD 8'h10
// ----------------------------------------
// Reset values and patterns
// ----------------------------------------
`define WDRG_WDT_CTRL_POR 8'h53
`define WDRG_GUARD_POR 8'h55
`define WDRG_GUARD_ALT 8'hAA
`define WDRG_WEN_A 5'h0A
`define WDRG_WEN_B 5'h15
`define WDRG_PORT_POR 8'hFF
`define WDRG_PC_POR 13'h0
// ----------------------------------------
// Field positions
// ----------------------------------------
`define WDRG_FLAG_WRF 0
`define WDRG_FLAG_GRF 3
`define WDRG_ST_TO 0
`define WDRG_ST_PDF 1
`define WDRG_CMD_CLRWDT 0
`define WDRG_CMD_HALT 1
`define WDRG_CMD_WAKE 2
// ----------------------------------------
// Timing
// ----------------------------------------
`define WDRG_CLK_HZ 50000000
`define WDRG_LOW_SPEED_INTERNAL_OSCILLATOR_HZ 32000
`define WDRG_LOW_SPEED_INTERNAL_OSCILLATOR_DIV (`WDRG_CLK_HZ / `WDRG_LOW_SPEED_INTERNAL_OSCILLATOR_HZ)
`define WDRG_SRESET_NS 40000
`define WDRG_SRESET_CYC ((`WDRG_SRESET_NS * 50 + 999) / 1000)
`define WDRG_RST_PULSE 3'h4
`endif

// ===== wdrg_delay.v
// Delayed reset request timer for one guard source
`timescale 1ns/1ps
module wdrg_delay #(
	parameter integer DELAY_CYC = 2000
) (
	input wire clk_i,
	input wire rst_i,
	input wire bad_i,
	output reg fire_o
);
	reg [15:0] cnt_q;
	reg armed_q;
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 16'h0000;
			armed_q <= 1'b0;
			fire_o <= 1'b0;
		end else begin
			fire_o <= 1'b0;
			if (!bad_i) begin
				armed_q <= 1'b0;
				cnt_q <= 16'h0000;
			end else if (!armed_q) begin
				if (cnt_q == DELAY_CYC[15:0] - 16'h0001) begin
					armed_q <= 1'b1;
					fire_o <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 16'h0001;
				end
			end
		end
	end
endmodule // wdrg_delay

// ===== wdrg_top.v
// Watchdog timer with register guard resets and reset flag bookkeeping
// Summary of operation
// - Watchdog counter ticks from a 32kHz low-speed enable derived from clk.
// - Period field selects 2^8,10,12,14,15,16,17,18 oscillator ticks.
// - Enable field 10101B or 01010B runs; other values reset after delay.
// - Enable field powers up as 01010B.
// - Invalid enable pattern reset sets flag bit 0.
// - Flag bit 0 cleared only by software writing zero.
// - Overflow while running resets device and sets timeout flag.
// - Overflow in sleep sets timeout, resets only PC and stack pointer.
// - Counter cleared by enable reset, clear instruction and halt.
// - Guard values 55h and AAh are no-op; others reset after delay.
// - Guard register powers up as 55h.
// - Guard violation reset sets flag bit 3.
// - Flag bit 3 held until software writes zero.
// - Flag bits 7 to 4 read as zero.
// - Power-on sets port data and control registers high.
// - Power-on clears program counter to zero.
// - Halt sets power-down, clears timeout, clears counter.
// - Power-down flag cleared by power-up and clear instruction.
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "wdrg_defs.vh"
module wdrg_top #(
	parameter integer SRESET_CYC = `WDRG_SRESET_CYC,
	parameter integer LOW_SPEED_INTERNAL_OSCILLATOR_DIV = `WDRG_LOW_SPEED_INTERNAL_OSCILLATOR_DIV
) (
	input wire clk_i,
	input wire rst_i,
	input wire [7:0] adr_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	input wire we_i,
	input wire [3:0] sel_i,
	input wire cyc_i,
	input wire stb_i,
	output reg ack_o,
	output reg err_o,
	output reg sys_reset_o,
	output reg pc_sp_reset_o,
	output reg [12:0] pc_o,
	output reg [7:0] port_data_o,
	output reg [7:0] port_ctrl_o,
	output reg sleeping_o
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [7:0] wdt_ctrl_q;
	reg [7:0] guard_q;
	reg wrf_q;
	reg grf_q;
	reg to_q;
	reg pdf_q;
	reg [11:0] div_q;
	reg low_speed_internal_oscillator_tick_q;
	reg [17:0] wdt_cnt_q;
	reg [2:0] rst_cnt_q;
	wire wdt_fire;
	wire guard_fire;
	wire req;
	wire wr;
	wire byte0;
	wire clr_cmd;
	wire halt_cmd;
	wire wake_cmd;
	wire wen_bad;
	wire guard_bad;
	reg ovf;
	reg [7:0] rdata;
	reg hit;
	assign req = cyc_i & stb_i & ~ack_o & ~err_o;
	// Writes commit on the edge where the master samples ack, while the request is still held
	assign wr = cyc_i & stb_i & ack_o & we_i;
	assign byte0 = sel_i[0];
	assign clr_cmd = wr & byte0 & (adr_i == `WDRG_OFS_CPU_CMD) & dat_i[`WDRG_CMD_CLRWDT];
	assign halt_cmd = wr & byte0 & (adr_i == `WDRG_OFS_CPU_CMD) & dat_i[`WDRG_CMD_HALT];
	assign wake_cmd = wr & byte0 & (adr_i == `WDRG_OFS_CPU_CMD) & dat_i[`WDRG_CMD_WAKE];
	assign wen_bad = (wdt_ctrl_q[7:3] != `WDRG_WEN_A) && (wdt_ctrl_q[7:3] != `WDRG_WEN_B);
	assign guard_bad = (guard_q != `WDRG_GUARD_POR) && (guard_q != `WDRG_GUARD_ALT);
	// ----------------------------------------
	// Delayed software resets
	// ----------------------------------------
	// Delay restarts if software repairs the pattern before it expires
	wdrg_delay #(.DELAY_CYC(SRESET_CYC)) u_wen_delay (
		.clk_i(clk_i),
		.rst_i(rst_i | sys_reset_o),
		.bad_i(wen_bad),
		.fire_o(wdt_fire)
	);
	wdrg_delay #(.DELAY_CYC(SRESET_CYC)) u_guard_delay (
		.clk_i(clk_i),
		.rst_i(rst_i | sys_reset_o),
		.bad_i(guard_bad),
		.fire_o(guard_fire)
	);
	// ----------------------------------------
	// Low-speed oscillator tick
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			div_q <= 12'h000;
			low_speed_internal_oscillator_tick_q <= 1'b0;
		end else if (div_q == LOW_SPEED_INTERNAL_OSCILLATOR_DIV[11:0] - 12'h001) begin
			div_q <= 12'h000;
			low_speed_internal_oscillator_tick_q <= 1'b1;
		end else begin
			div_q <= div_q + 12'h001;
			low_speed_internal_oscillator_tick_q <= 1'b0;
		end
	end
	// ----------------------------------------
	// Overflow select
	// ----------------------------------------
	always @* begin
		case (wdt_ctrl_q[2:0])
		3'h0: ovf = &wdt_cnt_q[7:0];
		3'h1: ovf = &wdt_cnt_q[9:0];
		3'h2: ovf = &wdt_cnt_q[11:0];
		3'h3: ovf = &wdt_cnt_q[13:0];
		3'h4: ovf = &wdt_cnt_q[14:0];
		3'h5: ovf = &wdt_cnt_q[15:0];
		3'h6: ovf = &wdt_cnt_q[16:0];
		default: ovf = &wdt_cnt_q[17:0];
		endcase
	end
	// ----------------------------------------
	// Watchdog counter and status flags
	// ----------------------------------------
	wire timeout;
	assign timeout = low_speed_internal_oscillator_tick_q & ovf & ~wen_bad;
	always @(posedge clk_i) begin
		if (rst_i) begin
			wdt_cnt_q <= 18'h00000;
			to_q <= 1'b0;
			pdf_q <= 1'b0;
		end else begin
			if (wdt_fire || clr_cmd || halt_cmd || sys_reset_o) begin
				wdt_cnt_q <= 18'h00000;
			end else if (low_speed_internal_oscillator_tick_q) begin
				wdt_cnt_q <= wdt_cnt_q + 18'h00001;
			end
			if (timeout) begin
				to_q <= 1'b1;
			end else if (halt_cmd) begin
				to_q <= 1'b0;
			end
			if (halt_cmd) begin
				pdf_q <= 1'b1;
			end else if (clr_cmd) begin
				pdf_q <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// Reset generation and CPU side state
	// ----------------------------------------
	// A device reset is stretched so the core sees it for several cycles
	always @(posedge clk_i) begin
		if (rst_i) begin
			rst_cnt_q <= 3'h0;
			sys_reset_o <= 1'b0;
			pc_sp_reset_o <= 1'b0;
			sleeping_o <= 1'b0;
			pc_o <= `WDRG_PC_POR;
			port_data_o <= `WDRG_PORT_POR;
			port_ctrl_o <= `WDRG_PORT_POR;
		end else begin
			pc_sp_reset_o <= 1'b0;
			if (halt_cmd) begin
				sleeping_o <= 1'b1;
			end else if (wake_cmd) begin
				sleeping_o <= 1'b0;
			end
			if (timeout && sleeping_o) begin
				pc_sp_reset_o <= 1'b1;
				pc_o <= `WDRG_PC_POR;
				sleeping_o <= 1'b0;
			end else if ((timeout && !sleeping_o) || wdt_fire || guard_fire) begin
				rst_cnt_q <= `WDRG_RST_PULSE;
				sys_reset_o <= 1'b1;
				pc_o <= `WDRG_PC_POR;
			end else if (rst_cnt_q != 3'h0) begin
				rst_cnt_q <= rst_cnt_q - 3'h1;
			end else begin
				sys_reset_o <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// Control registers and reset flags
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			wdt_ctrl_q <= `WDRG_WDT_CTRL_POR;
			guard_q <= `WDRG_GUARD_POR;
			wrf_q <= 1'b0;
			grf_q <= 1'b0;
		end else begin
			if (wdt_fire || guard_fire) begin
				wdt_ctrl_q <= `WDRG_WDT_CTRL_POR;
				guard_q <= `WDRG_GUARD_POR;
			end else if (wr && byte0) begin
				if (adr_i == `WDRG_OFS_WDT_CTRL) begin
					wdt_ctrl_q <= dat_i[7:0];
				end
				if (adr_i == `WDRG_OFS_GUARD) begin
					guard_q <= dat_i[7:0];
				end
			end
			// Set wins over a same-cycle software clear
			if (wdt_fire) begin
				wrf_q <= 1'b1;
			end else if (wr && byte0 && adr_i == `WDRG_OFS_RST_FLAGS && !dat_i[`WDRG_FLAG_WRF]) begin
				wrf_q <= 1'b0;
			end
			if (guard_fire) begin
				grf_q <= 1'b1;
			end else if (wr && byte0 && adr_i == `WDRG_OFS_RST_FLAGS && !dat_i[`WDRG_FLAG_GRF]) begin
				grf_q <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	always @* begin
		rdata = 8'h00;
		hit = 1'b1;
		case (adr_i)
		`WDRG_OFS_WDT_CTRL: rdata = wdt_ctrl_q;
		`WDRG_OFS_RST_FLAGS: rdata = {4'h0, grf_q, 2'b00, wrf_q};
		`WDRG_OFS_GUARD: rdata = guard_q;
		`WDRG_OFS_STATUS: rdata = {6'h00, pdf_q, to_q};
		`WDRG_OFS_CPU_CMD: rdata = 8'h00;
		default: hit = 1'b0;
		endcase
	end
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= req & hit;
			err_o <= req & ~hit;
			dat_o <= (req & hit & ~we_i) ? {24'h000000, rdata} : 32'h00000000;
		end
	end
endmodule // wdrg_top

// ===== wdrg_top_asserts.sv
// Checker for the watchdog and reset guard block
`timescale 1ns/1ps
module wdrg_chk #(
	parameter integer SRESET_CYC = 5,
	parameter integer LOW_SPEED_INTERNAL_OSCILLATOR_DIV = 2
) (
	input wire clk_i,
	input wire rst_i,
	input wire [7:0] adr_i,
	input wire [31:0] dat_i,
	input wire [31:0] dat_o,
	input wire we_i,
	input wire [3:0] sel_i,
	input wire cyc_i,
	input wire stb_i,
	input wire ack_o,
	input wire err_o,
	input wire sys_reset_o,
	input wire pc_sp_reset_o,
	input wire [12:0] pc_o,
	input wire [7:0] port_data_o,
	input wire [7:0] port_ctrl_o,
	input wire sleeping_o
);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	localparam int DMAX = SRESET_CYC + 4;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire take = cyc_i && stb_i && !ack_o && !err_o;
	wire wr0 = take && we_i && sel_i[0];
	wire mapped = adr_i inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	// Only the values the bench lets expire; repaired ones must not fire
	sequence s_bad_wr;
		wr0 && ((adr_i == 8'h08 && dat_i[7:0] == 8'h00) || (adr_i == 8'h00 && dat_i[7:0] == 8'h03));
	endsequence
	sequence s_quiet;
		!sys_reset_o [*2];
	endsequence
	a_bus_answer: assert property (take |=> (ack_o ^ err_o) && (err_o == !$past(mapped))) else $error("bad answer");
	a_ack_pulse: assert property (ack_o || err_o |=> !ack_o && !err_o) else $error("answer too long");
	a_data_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("stray read data");
	a_upper_zero: assert property (dat_o[31:8] == 24'h0) else $error("upper bits set");
	a_por_state: assert property (disable iff (1'b0) rst_i |=> port_data_o == 8'hFF && port_ctrl_o == 8'hFF
		&& pc_o == 13'h0 && !sys_reset_o) else $error("bad power-on state");
	a_reset_pulse: assert property ($rose(sys_reset_o) |-> sys_reset_o [*5] ##1 !sys_reset_o) else $error("pulse");
	a_bad_delay: assert property (s_bad_wr |=> s_quiet ##[1:DMAX] sys_reset_o) else $error("delay");
	a_sleep_wake: assert property (pc_sp_reset_o |-> !sys_reset_o ##1 !pc_sp_reset_o && !sleeping_o)
		else $error("sleep timeout wrong");
	a_halt_sleep: assert property (wr0 && adr_i == 8'h10 && dat_i[1] |=> ##[0:1] sleeping_o)
		else $error("halt ignored");
endmodule // wdrg_chk
bind wdrg_top wdrg_chk #(.SRESET_CYC(SRESET_CYC), .LOW_SPEED_INTERNAL_OSCILLATOR_DIV(LOW_SPEED_INTERNAL_OSCILLATOR_DIV)) wdrg_chk_i (.clk_i(clk_i), .rst_i(rst_i),
	.adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.ack_o(ack_o), .err_o(err_o), .sys_reset_o(sys_reset_o), .pc_sp_reset_o(pc_sp_reset_o), .pc_o(pc_o),
	.port_data_o(port_data_o), .port_ctrl_o(port_ctrl_o), .sleeping_o(sleeping_o));

// ===== wdrg_top_bench.sv
// Self-checking bench for the watchdog and reset guard block
`timescale 1ns/1ps
`define CK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module wdrg_top_bench;
	localparam int SR = 5;
	localparam int LD = 2;
	logic clk_i = 0;
	logic rst_i = 1;
	logic [7:0] adr_i = 0;
	logic [31:0] dat_i = 0;
	logic we_i = 0;
	logic [3:0] sel_i = 4'hF;
	logic cyc_i = 0;
	logic stb_i = 0;
	wire [31:0] dat_o;
	wire ack_o, err_o, sys_reset_o, pc_sp_reset_o, sleeping_o;
	wire [12:0] pc_o;
	wire [7:0] port_data_o, port_ctrl_o;
	int n_errors = 0;
	int samples_checked = 0;
	int n_rst = 0;
	int n, k;
	logic [7:0] q;
	logic e;
	wdrg_top #(.SRESET_CYC(SR), .LOW_SPEED_INTERNAL_OSCILLATOR_DIV(LD)) wdrg_top_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
		.dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
		.err_o(err_o), .sys_reset_o(sys_reset_o), .pc_sp_reset_o(pc_sp_reset_o), .pc_o(pc_o),
		.port_data_o(port_data_o), .port_ctrl_o(port_ctrl_o), .sleeping_o(sleeping_o));
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge sys_reset_o) n_rst++;
	task automatic end_of_test();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
		int i;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		adr_i <= a;
		we_i <= w;
		dat_i <= {24'h0, d};
		for (i = 0; i < 20 && !(ack_o || err_o); i++) begin
			@(posedge clk_i);
		end
		if (i == 20) begin
			n_errors++;
			end_of_test();
		end
		q = dat_o[7:0];
		e = err_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		bus(a, 1'b0, 8'h00);
		`CK("register", x, q)
	endtask
	// Counts cycles until either reset output rises
	task automatic wait_rst(input int lim);
		n = 0;
		while (!(sys_reset_o || pc_sp_reset_o) && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		if (n == lim) begin
			n_errors++;
			end_of_test();
		end
	endtask
	task automatic por_check();
		@(posedge clk_i);
		`CK("port data", 8'hFF, port_data_o)
		`CK("port ctrl", 8'hFF, port_ctrl_o)
		`CK("pc", 13'h0, pc_o)
		rd(8'h00, 8'h53);
		rd(8'h08, 8'h55);
		rd(8'h04, 8'h00);
		rd(8'h0C, 8'h00);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		por_check();
		bus(8'h20, 1'b1, 8'h00);
		`CK("unmapped", 1'b1, e)
		bus(8'h08, 1'b1, 8'hAA);
		rd(8'h08, 8'hAA);
		sel_i <= 4'hE;
		bus(8'h08, 1'b1, 8'h00);
		sel_i <= 4'hF;
		rd(8'h08, 8'hAA);
		// Bad value repaired well before the delay runs out
		bus(8'h08, 1'b1, 8'h5A);
		bus(8'h08, 1'b1, 8'h55);
		bus(8'h00, 1'b1, 8'hAB);
		repeat (20) @(posedge clk_i);
		`CK("no reset", 0, n_rst)
		rd(8'h00, 8'hAB);
		for (k = 0; k < 2; k++) begin
			bus(k ? 8'h00 : 8'h08, 1'b1, k ? 8'h03 : 8'h00);
			wait_rst(SR + 20);
			repeat (8) @(posedge clk_i);
			rd(8'h04, k ? 8'h01 : 8'h08);
			rd(k ? 8'h00 : 8'h08, k ? 8'h53 : 8'h55);
			bus(8'h04, 1'b1, 8'hFF);
			rd(8'h04, k ? 8'h01 : 8'h08);
			bus(8'h04, 1'b1, 8'h00);
			rd(8'h04, 8'h00);
		end
		for (k = 0; k < 3; k++) begin
			bus(8'h00, 1'b1, 8'h50 + 8'(k));
			bus(8'h10, 1'b1, 8'h01);
			wait_rst(40000);
			`CK("device reset", 1'b1, sys_reset_o)
			`CK("period", 1'b1, n > (LD << (8 + 2 * k)) - 10 && n < (LD << (8 + 2 * k)) + 10)
			repeat (8) @(posedge clk_i);
			rd(8'h0C, 8'h01);
		end
		bus(8'h00, 1'b1, 8'h50);
		bus(8'h10, 1'b1, 8'h02);
		rd(8'h0C, 8'h02);
		`CK("sleeping", 1'b1, sleeping_o)
		k = n_rst;
		wait_rst(1000);
		`CK("sleep timeout", 1'b1, pc_sp_reset_o)
		`CK("halt clears", 1'b1, n > (LD << 8) - 30 && n < (LD << 8) + 10)
		repeat (8) @(posedge clk_i);
		`CK("only pc reset", k, n_rst)
		`CK("woken", 1'b0, sleeping_o)
		rd(8'h0C, 8'h03);
		bus(8'h10, 1'b1, 8'h01);
		rd(8'h0C, 8'h01);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		por_check();
		end_of_test();
	end
endmodule // wdrg_top_bench
